// [src/adc_consts.svh]
// Named constants for the convert strobe and serial readout block.
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ---------------------------------------------------------------
// Result format
// ---------------------------------------------------------------
`define ADC_RES_BITS   14
`define ADC_CODE_MAX   14'h3FFF
`define ADC_CODE_MIN   14'h0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ADC_MCLK_KHZ   10000
`define ADC_CONV_NS    1600
`define ADC_NS_PER_US  1000

// ---------------------------------------------------------------
// Serial clock edge counter
// ---------------------------------------------------------------
`define ADC_CNT_W      8

`endif

// [src/adc_convert_serial_readout.sv]
// Conversion start, mode selection and serial result readout of the converter.
`timescale 1ns/10ps
`default_nettype none
`include "adc_consts.svh"

// Behaviour
// - Each convert strobe rising edge starts a conversion and latches the mode.
// - Serial input low at that edge selects chain mode.
// - Serial input high at that edge selects chip-select mode.
// - Chip-select mode: output enabled while serial input or strobe is low.
// - Chip-select mode: busy indicator when selected as conversion completes.
// - While selected, result shifts out synchronised to the serial clock.
// - Chain mode: serial input reappears on output 14 serial clocks later.
// - Conversion runs on the internal clock; no serial clock needed.
// - Result is straight binary, saturating at 3FFF and 0000.
module adc_convert_serial_readout #(
  parameter int CONV_NS  = `ADC_CONV_NS,
  parameter int RES_BITS = `ADC_RES_BITS,
  parameter int CNT_W    = `ADC_CNT_W
) (
  // Internal conversion clock and reset
  input  wire logic                mclk,
  input  wire logic                srst,
  // Host pins
  input  wire logic                convert_strobe,
  input  wire logic                serial_mode_chain_in,
  input  wire logic                serial_clk,
  output logic                     serial_result_out,
  output logic                     serial_result_out_oe,
  // Comparator result from the analog core, on mclk
  input  wire logic [RES_BITS-1:0] analog_code,
  input  wire logic                over_range,
  input  wire logic                under_range,
  // Status
  output logic                     converting
);

  // ---------------------------------------------------------------
  // Derived timing
  // ---------------------------------------------------------------
  // A least time, so the cycle count rounds up.
  localparam int CONV_CYC_RAW = (CONV_NS * (`ADC_MCLK_KHZ / `ADC_NS_PER_US)
                                 + `ADC_NS_PER_US - 1) / `ADC_NS_PER_US;
  localparam int CONV_CYC     = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic                   cnv_s;
  logic                   sdi_s;
  logic                   cnv_d;
  logic                   cnv_rise;

  sync2 #(.WIDTH(2)) u_pin_sync (
    .clk (mclk),
    .d   ({convert_strobe, serial_mode_chain_in}),
    .q   ({cnv_s, sdi_s})
  );

  // Previous strobe level for the rising edge detect.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnv_d <= 1'b0;
    end else begin
      cnv_d <= cnv_s;
    end
  end

  assign cnv_rise = cnv_s & ~cnv_d;

  // ---------------------------------------------------------------
  // Mode latch
  // ---------------------------------------------------------------
  adc_pkg::mode_t mode;

  // Both pins pass the same synchroniser depth, so they are seen together.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode <= adc_pkg::MODE_CS;
    end else if (cnv_rise) begin
      mode <= sdi_s ? adc_pkg::MODE_CS
                    : adc_pkg::MODE_CHAIN;
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer on the internal clock
  // ---------------------------------------------------------------
  adc_pkg::conv_state_t   state;
  logic [15:0]            conv_cnt;
  logic                   conv_done;
  logic [RES_BITS-1:0]    sample_code;
  logic [RES_BITS-1:0]    result_hold;
  logic                   busy_en;
  logic                   selected_s;

  assign selected_s = ~cnv_s | ~sdi_s;
  assign conv_done  = (state == adc_pkg::ST_CONVERT) && (conv_cnt == CONV_LAST);
  assign converting = (state == adc_pkg::ST_CONVERT);

  // A new rising edge during a conversion restarts it; the host should not do so.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state    <= adc_pkg::ST_IDLE;
      conv_cnt <= 16'h0000;
    end else begin
      unique case (state)
        adc_pkg::ST_IDLE: begin
          conv_cnt <= 16'h0000;
          if (cnv_rise) begin
            state <= adc_pkg::ST_CONVERT;
          end
        end
        adc_pkg::ST_CONVERT: begin
          conv_cnt <= conv_cnt + 16'h0001;
          if (cnv_rise) begin
            conv_cnt <= 16'h0000;
          end else if (conv_done) begin
            state <= adc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sample the core at the strobe edge, saturating out-of-range inputs.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sample_code <= `ADC_CODE_MIN;
    end else if (cnv_rise) begin
      if (over_range) begin
        sample_code <= `ADC_CODE_MAX;
      end else if (under_range) begin
        sample_code <= `ADC_CODE_MIN;
      end else begin
        sample_code <= analog_code;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial clock edge count crossing into the internal domain
  // ---------------------------------------------------------------
  logic [CNT_W-1:0]       cnt_l = '0;
  logic [CNT_W-1:0]       gray_l = '0;
  logic [CNT_W-1:0]       next_cnt_l;
  logic [CNT_W-1:0]       gray_m;
  logic [CNT_W-1:0]       cnt_m;
  logic [CNT_W-1:0]       base;

  sync2 #(.WIDTH(CNT_W)) u_gray_sync (
    .clk (mclk),
    .d   (gray_l),
    .q   (gray_m)
  );

  // Gray to binary conversion of the synchronised count.
  always_comb begin
    cnt_m[CNT_W-1] = gray_m[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      cnt_m[i] = cnt_m[i+1] ^ gray_m[i];
    end
  end

  // At completion the result, the busy choice and the edge count are frozen.
  // The serial side reads them only after completion, when they are stable.
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_hold <= `ADC_CODE_MIN;
      busy_en     <= 1'b0;
      base        <= '0;
    end else if (conv_done) begin
      result_hold <= sample_code;
      busy_en     <= (mode == adc_pkg::MODE_CS) && selected_s;
      base        <= cnt_m;
    end
  end

  // ---------------------------------------------------------------
  // Serial clock domain
  // ---------------------------------------------------------------
  logic [RES_BITS-1:0]    chain_dly = '0;
  logic [CNT_W-1:0]       idx;
  logic [CNT_W-1:0]       pos;

  assign next_cnt_l = cnt_l + {{(CNT_W-1){1'b0}}, 1'b1};

  // Output bits advance on the falling edge, so the host samples on the rise.
  always_ff @(negedge serial_clk) begin
    cnt_l  <= next_cnt_l;
    gray_l <= next_cnt_l ^ (next_cnt_l >> 1);
  end

  // Upstream data enters on the rising edge; the last stage is 14 clocks old.
  always_ff @(posedge serial_clk) begin
    chain_dly <= {chain_dly[RES_BITS-2:0], serial_mode_chain_in};
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  assign idx = cnt_l - base;
  assign pos = busy_en ? (idx - {{(CNT_W-1){1'b0}}, 1'b1}) : idx;

  // The count wraps after 2**CNT_W clocks, a limit on very long chains.
  always_comb begin
    if (converting) begin
      serial_result_out = 1'b0;
    end else if (busy_en && (idx == '0)) begin
      serial_result_out = 1'b1;
    end else if (pos < CNT_W'(RES_BITS)) begin
      serial_result_out = result_hold[RES_BITS-1-int'(pos)];
    end else if (mode == adc_pkg::MODE_CHAIN) begin
      serial_result_out = chain_dly[RES_BITS-1];
    end else begin
      serial_result_out = 1'b0;
    end
  end

  // Chain mode always drives; chip-select mode drives while selected.
  always_comb begin
    if (mode == adc_pkg::MODE_CHAIN) begin
      serial_result_out_oe = 1'b1;
    end else begin
      serial_result_out_oe = selected_s;
    end
  end

endmodule

`default_nettype wire

// [src/adc_pkg.sv]
// Types shared by the convert strobe and serial readout block.
package adc_pkg;

  // Interface mode chosen at the rising edge of the convert strobe.
  typedef enum logic {
    MODE_CS,
    MODE_CHAIN
  } mode_t;

  // Conversion sequencer states.
  typedef enum logic {
    ST_IDLE,
    ST_CONVERT
  } conv_state_t;

endpackage

// [src/sync2.sv]
// Two flip-flop synchroniser for levels and gray-coded words.
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock of the receiving domain
  input  wire logic             clk,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule

`default_nettype wire

// [verif/adc_convert_serial_readout_asserts.sv]
// Concurrent checks of the convert strobe and serial readout block.
`timescale 1ns/10ps
`default_nettype none
module adc_convert_serial_readout_asserts #(
  parameter int CONV_NS  = 1600,
  parameter int RES_BITS = 14
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                srst,
  // Pins, core and status
  input wire logic                convert_strobe,
  input wire logic                serial_mode_chain_in,
  input wire logic                serial_result_out,
  input wire logic                serial_result_out_oe,
  input wire logic [RES_BITS-1:0] analog_code,
  input wire logic                over_range,
  input wire logic                under_range,
  input wire logic                converting
);
  localparam int CONV_CYC = (CONV_NS * 10 + 999) / 1000;
  logic       strobe_q;
  logic       chain_q;
  logic [7:0] conv_cnt;
  wire        nobusy = chain_q | (convert_strobe & serial_mode_chain_in);
  // Mode is mirrored from the raw pins; the bench holds them steady past the synchronisers.
  always_ff @(posedge mclk) begin
    strobe_q <= convert_strobe;
    if (srst) chain_q <= 1'b0;
    else if (convert_strobe && !strobe_q) chain_q <= !serial_mode_chain_in;
  end
  // Counts the cycles of one conversion.
  always_ff @(posedge mclk) begin
    if (srst || !converting) conv_cnt <= 8'h00;
    else conv_cnt <= conv_cnt + 8'h01;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_rise;
    $rose(convert_strobe) && !converting;
  endsequence
  sequence s_done;
    $fell(converting) && nobusy;
  endsequence
  AST_START: assert property (s_rise |-> ##[2:4] $rose(converting))
    else $error("conversion did not start");
  AST_CAUSE: assert property ($rose(converting) |-> $past(convert_strobe, 2))
    else $error("conversion without strobe");
  AST_CONV_LEN: assert property ($fell(converting) |-> conv_cnt == CONV_CYC)
    else $error("conversion length wrong");
  AST_CHAIN_OE: assert property (chain_q && converting |-> serial_result_out_oe)
    else $error("chain output not driven");
  AST_CS_OE: assert property (!chain_q && converting |->
    serial_result_out_oe == !($past(convert_strobe, 2) && $past(serial_mode_chain_in, 2)))
    else $error("enable does not follow pins");
  AST_BUSY: assert property ($fell(converting) && !chain_q && !serial_mode_chain_in
    |-> serial_result_out)
    else $error("busy indicator missing");
  AST_BUSY_LOW: assert property (!chain_q && converting && $past(converting)
    |-> !serial_result_out || !serial_result_out_oe)
    else $error("output high while converting");
  AST_MSB: assert property (s_done |-> serial_result_out ==
    (over_range || (!under_range && analog_code[RES_BITS-1])))
    else $error("first bit wrong");
endmodule
bind adc_convert_serial_readout adc_convert_serial_readout_asserts #(.CONV_NS(CONV_NS),
  .RES_BITS(RES_BITS)) chk (.mclk, .srst, .convert_strobe, .serial_mode_chain_in,
  .serial_result_out, .serial_result_out_oe, .analog_code, .over_range, .under_range,
  .converting);
`default_nettype wire

// [verif/adc_convert_serial_readout_bench.sv]
// Self-checking bench for the convert strobe and serial readout block.
`timescale 1ns/10ps
`default_nettype none
module adc_convert_serial_readout_bench;
  logic        mclk, srst, convert_strobe, serial_mode_chain_in, over_range, under_range;
  logic        serial_clk, serial_result_out, serial_result_out_oe, converting;
  logic [13:0] analog_code;
  logic        exp_q[$];
  logic [31:0] seed = 32'h00002DE0;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  host_model host (.serial_clk);
  adc_convert_serial_readout dut (.mclk, .srst, .convert_strobe, .serial_mode_chain_in,
    .serial_clk, .serial_result_out, .serial_result_out_oe, .analog_code, .over_range,
    .under_range, .converting);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Each test takes under a hundred cycles, so the ceiling is generous; a hang costs a mismatch.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // Each serial clock rise yields one bit, checked against the oldest note.
  always @(posedge serial_clk) begin
    if (exp_q.size() > 0) check(serial_result_out, exp_q.pop_front());
  end
  // Mode 0 plain select, 1 busy, 2 chain; kind 0 code, 1 over, 2 under range.
  task automatic run(input int mode, input int kind);
    logic [13:0] res;
    logic [31:0] d;
    seed = xs(seed);
    d = xs(seed);
    res = kind == 1 ? 14'h3FFF : kind == 2 ? 14'h0000 : seed[29:16];
    @(posedge mclk);
    analog_code <= seed[29:16];
    over_range <= kind == 1;
    under_range <= kind == 2;
    serial_mode_chain_in <= mode != 2;
    repeat (4) @(posedge mclk);
    convert_strobe <= 1'b1;
    repeat (2) @(posedge mclk);
    if (mode == 1) serial_mode_chain_in <= 1'b0;
    if (mode == 2) serial_mode_chain_in <= d[0];
    for (int i = 0; i < 40 && converting !== 1'b1; i++) @(posedge mclk);
    for (int i = 0; i < 40 && converting !== 1'b0; i++) @(posedge mclk);
    #1;
    if (mode == 0) begin
      check(serial_result_out_oe, 1'b0);
      @(posedge mclk);
      convert_strobe <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      check(serial_result_out_oe, 1'b1);
    end
    if (mode == 1) exp_q.push_back(1'b1);
    for (int k = 13; k >= 0; k--) exp_q.push_back(res[k]);
    for (int k = 0; k < 5; k++) exp_q.push_back(mode == 2 ? d[k] : 1'b0);
    fork
      host.frame(exp_q.size());
      for (int k = 1; k < 19 && mode == 2; k++) @(negedge serial_clk) serial_mode_chain_in <= d[k];
    join
    check(exp_q.size() == 0, 1'b1);
    @(posedge mclk);
    convert_strobe <= 1'b0;
    serial_mode_chain_in <= 1'b1;
    $display("test mode %0d kind %0d done", mode, kind);
  endtask
  initial begin
    srst = 1'b1;
    convert_strobe = 1'b0;
    serial_mode_chain_in = 1'b1;
    analog_code = 14'h0000;
    over_range = 1'b0;
    under_range = 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    for (int m = 0; m < 3; m++) for (int k = 0; k < 3; k++) run(m, k);
    test_done();
  end
endmodule
`default_nettype wire

// [verif/host_model.sv]
// Host side model that bursts the serial clock in frames.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Serial clock toward the converter
  output var logic serial_clk
);
  initial serial_clk = 1'b0;
  // The clock stands low between frames so no stray edge moves the bit index.
  task automatic frame(input int n);
    #37;
    repeat (n) begin
      serial_clk = 1'b1;
      #80;
      serial_clk = 1'b0;
      #80;
    end
  endtask
endmodule
`default_nettype wire
